// File: rtl/aspi_defs.svh
// Purpose: timing counts, field positions, command codes and reset values for the angle port
// Assumes: included by its bare name wherever a constant is needed
// Notes: figures are kept in their own unit, cycle counts are derived from the 8 ns clock
`ifndef ASPI_DEFS_SVH
`define ASPI_DEFS_SVH
`define ASPI_CLK_PERIOD_NS 8
`define ASPI_SAMPLE_RATE_KHZ 1000
`define ASPI_SAMPLE_CYC ((1000000 / `ASPI_SAMPLE_RATE_KHZ) / `ASPI_CLK_PERIOD_NS)
`define ASPI_NVM_WAIT_MS 20
`define ASPI_NVM_WAIT_CYC ((`ASPI_NVM_WAIT_MS * 1000000) / `ASPI_CLK_PERIOD_NS)
`define ASPI_CMD_READ 3'h2
`define ASPI_CMD_WRITE 3'h4
`define ASPI_REG_ZERO_LO 5'h00
`define ASPI_REG_ZERO_HI 5'h01
`define ASPI_REG_PPT_LO 5'h04
`define ASPI_REG_PPT_HI 5'h05
`define ASPI_REG_THRESH 5'h06
`define ASPI_REG_DIR 5'h09
`define ASPI_REG_FLAGS 5'h1B
`define ASPI_RST_PPT_LO 8'hC0
`define ASPI_RST_PPT_HI 8'h0F
`define ASPI_RST_THRESH 8'h1C
`define ASPI_FRAME_BITS 5'h10
`define ASPI_FILT_SHIFT 4
`endif

// File: rtl/aspi_pkg.sv
// Purpose: shared types for the angle port
// Assumes: constants live in aspi_defs.svh
// Notes: none
package aspi_pkg;
  typedef struct packed {
    logic [2:0] cmd;
    logic [4:0] addr;
    logic [7:0] data;
  } aspi_frame_t;
  typedef enum logic [1:0] {
    ASPI_RSP_ANGLE,
    ASPI_RSP_REG,
    ASPI_RSP_PEND
  } aspi_rsp_t;
  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } aspi_abz_t;
endpackage : aspi_pkg

// File: rtl/aspi_sync.sv
// Purpose: two-flop level synchroniser, one per bit
// Assumes: destination clock is i_ref_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module aspi_sync #(
  parameter int W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  // two stages for metastability settling
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end
  assign o_q = q_ff;
endmodule : aspi_sync

// File: rtl/aspi_filter.sv
// Purpose: second-order smoothing of the raw angle samples
// Assumes: one sample strobe per microsecond
// Notes: two cascaded leaky stages with a lead term give a zero steady-state lag
`timescale 1ns/1ps
`include "aspi_defs.svh"
module aspi_filter (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_stb,
  input wire logic [15:0] i_raw,
  output logic [15:0] o_ang
);
  logic signed [31:0] s1_ff, s2_ff;
  logic signed [31:0] err1, err2;
  logic [15:0] ang_ff;
  // errors are wrapped to 16 bits so the angle rolls over cleanly
  assign err1 = 32'(signed'(16'(i_raw - s1_ff[31:16]))) <<< 16;
  assign err2 = 32'(signed'(16'(s1_ff[31:16] - s2_ff[31:16]))) <<< 16;
  // R13: lead-lag filter stages
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      ang_ff <= '0;
    end else if (i_stb) begin
      s1_ff <= s1_ff + (err1 >>> `ASPI_FILT_SHIFT);
      s2_ff <= s2_ff + (err2 >>> `ASPI_FILT_SHIFT);
      ang_ff <= 16'(2 * s1_ff[31:16] - s2_ff[31:16]); // lead term cancels lag
    end
  end
  assign o_ang = ang_ff;
endmodule : aspi_filter

// File: rtl/aspi_port.sv
// Purpose: serial configuration and angle readout port with field flags and ABZ outputs
// Assumes: controller keeps its own spacing and clock-rate limits
// Notes: link logic runs on the serial clock, registers on i_ref_clk
// Functional notes
// R1: accept modes 0 and 3 automatically
// R2: controller serial clock up to 25MHz
// R3: commands are exactly 16-bit frames
// R4: sample rising, launch falling, MSB first
// R5: controller idles select 150 ns between angles
// R6: controller idles 750 ns around register reads
// R7: controller waits for memory before readout
// R8: low flag when field below low threshold
// R9: high flag when field above high threshold
// R10: each ABZ channel has inverse pin
// R11: weak pull-down while data out floats
// R12: new angle sample every microsecond
// R13: smooth samples, no steady-state latency
// R14: direction and zero reference are programmable
// R15: read is command frame then value frame
// R16: write frame then echo of stored value
// R17: controller waits 20ms before acknowledge frame
// R18: angle shifted MSB first, zero padded
// R19: select high resets frame bit counter
`timescale 1ns/1ps
`include "aspi_defs.svh"
module aspi_port #(
  parameter int NVM_WAIT_CYC = `ASPI_NVM_WAIT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic [15:0] i_raw_angle,
  input wire logic [7:0] i_field_level,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_miso_pd_en,
  output logic o_abz_a,
  output logic o_abz_a_n,
  output logic o_abz_b,
  output logic o_abz_b_n,
  output logic o_abz_z,
  output logic o_abz_z_n,
  output logic o_field_low_flag,
  output logic o_field_high_flag,
  output logic [15:0] o_angle
);
  // ---------------- link domain (serial clock) ----------------
  logic [4:0] bit_cnt_ff;
  logic [14:0] shin_ff;
  logic [15:0] shout_ff;
  logic [15:0] frame_ff;
  logic frame_tgl_ff;
  logic [15:0] load_word;
  logic [15:0] tx_word_s;
  logic [15:0] tx_hold_ff;
  logic cs_sync;
  logic [3:0] out_idx_ff;
  // R1: mode 0 and 3 both sample on rising edges, so no polarity setup is needed
  // R19: select high resets the counter asynchronously
  // R4: capture on rising edge, MSB first
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_ff <= 5'h00;
      shin_ff <= 15'h0000;
    end else begin
      bit_cnt_ff <= (bit_cnt_ff == `ASPI_FRAME_BITS - 5'h01) ? 5'h00 : bit_cnt_ff + 5'h01;
      shin_ff <= {shin_ff[13:0], i_mosi};
    end
  end
  // R3: a frame completes on its sixteenth rising edge
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_ff <= 16'h0000;
      frame_tgl_ff <= 1'b0;
    end else if (!i_cs_n && bit_cnt_ff == `ASPI_FRAME_BITS - 5'h01) begin
      frame_ff <= {shin_ff, i_mosi};
      frame_tgl_ff <= ~frame_tgl_ff;
    end
  end
  // the response is a snapshot frozen in the reference domain while select is low,
  // so it stays quasi-static for the whole frame and needs no sclk edge to load
  assign load_word = tx_hold_ff;
  // output bit index follows the capture count, but only on falling edges;
  // in mode 3 the first falling edge comes before any rising edge and keeps index 0
  // R4: launch on falling edge
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      out_idx_ff <= 4'h0;
    end else begin
      out_idx_ff <= bit_cnt_ff[3:0];
    end
  end
  // R18: MSB first; the shifted word carries its own zero fill
  assign shout_ff = load_word;
  assign o_miso = shout_ff[4'hF - out_idx_ff];
  // R11: pull-down enabled exactly while the data line floats
  assign o_miso_oe = ~i_cs_n;
  assign o_miso_pd_en = i_cs_n;

  // ---------------- system domain ----------------
  logic [0:0] tgl_sync;
  logic tgl_d_ff;
  logic frame_stb;
  aspi_sync #(.W(1)) u_tgl_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_d(frame_tgl_ff),
    .o_q(tgl_sync[0])
  );
  // select level also crosses, to decide when the response snapshot may move
  aspi_sync #(.W(1)) u_cs_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_cs_n),
    .o_q(cs_sync)
  );
  assign frame_stb = tgl_sync[0] ^ tgl_d_ff;
  aspi_pkg::aspi_frame_t cmd_frame;
  assign cmd_frame = frame_ff; // stable since the toggle crossed after the load
  logic [7:0] zero_lo_ff, zero_hi_ff, ppt_lo_ff, ppt_hi_ff, thresh_ff, dir_ff;
  logic [7:0] rd_val;
  logic [7:0] rsp_val_ff;
  logic [7:0] prev_val_ff;
  aspi_pkg::aspi_rsp_t rsp_ff;
  logic [31:0] nvm_cnt_ff;
  logic [15:0] filt_angle;
  logic [15:0] angle_ff;
  logic fl_low, fl_high;
  logic is_rd, is_wr;
  assign is_rd = frame_stb && cmd_frame.cmd == `ASPI_CMD_READ;
  assign is_wr = frame_stb && cmd_frame.cmd == `ASPI_CMD_WRITE;
  // register readback mux, flags register returns live flags in bits 7 and 6
  assign rd_val = (cmd_frame.addr == `ASPI_REG_ZERO_LO) ? zero_lo_ff :
                  (cmd_frame.addr == `ASPI_REG_ZERO_HI) ? zero_hi_ff :
                  (cmd_frame.addr == `ASPI_REG_PPT_LO) ? ppt_lo_ff :
                  (cmd_frame.addr == `ASPI_REG_PPT_HI) ? ppt_hi_ff :
                  (cmd_frame.addr == `ASPI_REG_THRESH) ? thresh_ff :
                  (cmd_frame.addr == `ASPI_REG_DIR) ? dir_ff :
                  (cmd_frame.addr == `ASPI_REG_FLAGS) ? {fl_high, fl_low, 6'h00} : 8'h00;
  // R16: write stores value; R15: read prepares value for next frame
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgl_d_ff <= 1'b0;
      zero_lo_ff <= 8'h00;
      zero_hi_ff <= 8'h00;
      ppt_lo_ff <= `ASPI_RST_PPT_LO;
      ppt_hi_ff <= `ASPI_RST_PPT_HI;
      thresh_ff <= `ASPI_RST_THRESH;
      dir_ff <= 8'h00;
      rsp_ff <= aspi_pkg::ASPI_RSP_ANGLE;
      rsp_val_ff <= 8'h00;
      prev_val_ff <= 8'h00;
      nvm_cnt_ff <= 32'h0000_0000;
    end else begin
      tgl_d_ff <= tgl_sync[0];
      if (nvm_cnt_ff != 32'h0000_0000) begin
        nvm_cnt_ff <= nvm_cnt_ff - 32'h0000_0001;
      end
      if (is_wr) begin
        prev_val_ff <= rd_val;
        rsp_val_ff <= cmd_frame.data;
        rsp_ff <= aspi_pkg::ASPI_RSP_PEND;
        nvm_cnt_ff <= 32'(NVM_WAIT_CYC);
        unique case (cmd_frame.addr)
          `ASPI_REG_ZERO_LO: zero_lo_ff <= cmd_frame.data;
          `ASPI_REG_ZERO_HI: zero_hi_ff <= cmd_frame.data;
          `ASPI_REG_PPT_LO: ppt_lo_ff <= cmd_frame.data;
          `ASPI_REG_PPT_HI: ppt_hi_ff <= cmd_frame.data;
          `ASPI_REG_THRESH: thresh_ff <= cmd_frame.data;
          `ASPI_REG_DIR: dir_ff <= cmd_frame.data;
          default: ;
        endcase
      end else if (is_rd) begin
        rsp_val_ff <= rd_val;
        rsp_ff <= aspi_pkg::ASPI_RSP_REG;
      end else if (frame_stb) begin
        rsp_ff <= aspi_pkg::ASPI_RSP_ANGLE;
      end else if (rsp_ff == aspi_pkg::ASPI_RSP_PEND && nvm_cnt_ff == 32'h0000_0000) begin
        rsp_ff <= aspi_pkg::ASPI_RSP_REG;
      end
    end
  end
  // R17: before the memory wait ends the echo shows the old value
  assign tx_word_s = (rsp_ff == aspi_pkg::ASPI_RSP_REG) ? {rsp_val_ff, 8'h00} :
                     (rsp_ff == aspi_pkg::ASPI_RSP_PEND) ? {prev_val_ff, 8'h00} : angle_ff;
  // snapshot follows the live word only while select is seen high; the angle moves
  // with every microsecond sample, and a frame must carry one consistent word
  // limitation: a controller that captures its first bit within about three reference
  // cycles of select falling may see the word still changing
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_hold_ff <= 16'h0000;
    end else if (cs_sync) begin
      tx_hold_ff <= tx_word_s;
    end
  end
  // R12: sample strobe every microsecond
  logic [7:0] samp_cnt_ff;
  logic samp_stb;
  assign samp_stb = samp_cnt_ff == 8'(`ASPI_SAMPLE_CYC - 1);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_cnt_ff <= 8'h00;
    end else begin
      samp_cnt_ff <= samp_stb ? 8'h00 : samp_cnt_ff + 8'h01;
    end
  end
  aspi_filter u_filter (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_stb(samp_stb),
    .i_raw(i_raw_angle),
    .o_ang(filt_angle)
  );
  // R14: direction bit 7 reverses count, zero offset subtracted
  logic [15:0] dir_angle;
  assign dir_angle = dir_ff[7] ? 16'(16'h0000 - filt_angle) : filt_angle;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      angle_ff <= 16'h0000;
    end else begin
      angle_ff <= 16'(dir_angle - {zero_hi_ff, zero_lo_ff});
    end
  end
  assign o_angle = angle_ff;
  // R8 R9: threshold compare, thresholds scaled to top bits of field level
  assign fl_low = i_field_level[7:5] < thresh_ff[7:5];
  assign fl_high = i_field_level[7:5] > thresh_ff[4:2];
  // quadrature: pulses per turn = 64*(ppt+1), each pulse four edges
  logic [5:0] ppt;
  logic [15:0] qpos;
  logic [23:0] qprod;
  assign ppt = {ppt_hi_ff[3:0], ppt_lo_ff[7:6]};
  assign qprod = angle_ff * ({2'b00, ppt} + 8'h01);
  assign qpos = qprod[23:8];
  aspi_pkg::aspi_abz_t abz_ff;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      abz_ff <= '0;
      o_field_low_flag <= 1'b0;
      o_field_high_flag <= 1'b0;
    end else begin
      abz_ff.a <= qpos[1];
      abz_ff.b <= qpos[1] ^ qpos[0];
      abz_ff.z <= qprod[23:8] == 16'h0000;
      o_field_low_flag <= fl_low;
      o_field_high_flag <= fl_high;
    end
  end
  // R10: complementary pins always the inverse
  assign o_abz_a = abz_ff.a;
  assign o_abz_a_n = ~abz_ff.a;
  assign o_abz_b = abz_ff.b;
  assign o_abz_b_n = ~abz_ff.b;
  assign o_abz_z = abz_ff.z;
  assign o_abz_z_n = ~abz_ff.z;

  // ---------------- checks ----------------
  a_abz_compl: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
    (o_abz_a != o_abz_a_n) && (o_abz_b != o_abz_b_n) && (o_abz_z != o_abz_z_n))
    else $error("abz complement broken");
  a_pd_float: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R11
    o_miso_pd_en == !o_miso_oe) else $error("pull-down not tied to float");
  a_low_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R8
    fl_low |=> o_field_low_flag) else $error("low flag missed");
  a_high_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R9
    fl_high |=> o_field_high_flag) else $error("high flag missed");
  a_samp_rate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
    samp_stb |=> !samp_stb [*8]) else $error("sample strobe too fast");
  a_wr_pend: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R17
    is_wr |=> rsp_ff == aspi_pkg::ASPI_RSP_PEND) else $error("write not pending");
  a_rd_value: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R15
    is_rd |=> rsp_ff == aspi_pkg::ASPI_RSP_REG && rsp_val_ff == $past(rd_val))
    else $error("read value not staged");
  a_wr_store: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R16
    is_wr && cmd_frame.addr == `ASPI_REG_DIR |=> dir_ff == $past(cmd_frame.data))
    else $error("write not stored");
  // the response word must not move while a frame is running
  a_snap_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R18
    !cs_sync |=> $stable(tx_hold_ff)) else $error("response moved in frame");
  // the capture count never leaves one frame
  a_cnt_range: assert property (@(posedge i_sclk) disable iff (i_cs_n) // R3
    bit_cnt_ff <= 5'h0F) else $error("bit count out of frame");
  // a write always starts a full memory wait
  a_nvm_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R17
    is_wr |=> nvm_cnt_ff == 32'(NVM_WAIT_CYC)) else $error("memory wait not started");
endmodule : aspi_port

// File: tb/aspi_ctrl_model.sv
// Purpose: behavioural spi controller facing the angle port
// Assumes: 125 ns serial period, phase unrelated to i_ref_clk
// Notes: sclk stands still between frames; mosi drops to its pull-down level when idle
`timescale 1ns/1ps
module aspi_ctrl_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // one frame; a short nbits leaves a partial frame on purpose
  task automatic xfer(input logic mode3, input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    // odd offset keeps link edges off the reference clock edges
    #1.3;
    // idle sclk level sets the mode
    o_sclk = mode3;
    #62.5;
    o_cs_n = 1'b0;
    // 8 MHz clock, msb first, launch falling, capture rising
    for (int i = 15; i >= 16 - nbits; i--) begin
      #62.5;
      o_sclk = 1'b0;
      o_mosi = tx[i];
      #62.5;
      o_sclk = 1'b1;
      rx[i] = i_miso;
    end
    #62.5;
    o_sclk = mode3;
    #62.5;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    #800;
  endtask : xfer
endmodule : aspi_ctrl_model

// File: tb/test_angle_sensor_spi_config_port.sv
// Purpose: self-checking bench for the angle port
// Assumes: controller model on the link, small memory wait
// Notes: filter settles over hundreds of samples, so angle checks allow a margin
`timescale 1ns/1ps
`include "aspi_defs.svh"
module test_angle_sensor_spi_config_port;
  localparam int NVM = 400;
  logic clk, rst_n, sclk, cs_n, mosi, miso_w;
  logic miso, oe, pd_en, a, a_n, b, b_n, z, z_n, flo, fhi;
  logic [15:0] raw, ang, rx;
  logic [7:0] fld;
  int n_fail, compares;
  aspi_port #(.NVM_WAIT_CYC(NVM)) dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_mosi(mosi), .i_raw_angle(raw), .i_field_level(fld), .o_miso(miso),
    .o_miso_oe(oe), .o_miso_pd_en(pd_en), .o_abz_a(a), .o_abz_a_n(a_n), .o_abz_b(b),
    .o_abz_b_n(b_n), .o_abz_z(z), .o_abz_z_n(z_n), .o_field_low_flag(flo),
    .o_field_high_flag(fhi), .o_angle(ang));
  aspi_ctrl_model ctl_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_w));
  // pad level: pull-down holds the floating line low, else it shows garbage
  assign miso_w = oe ? miso : (pd_en ? 1'b0 : ~miso);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // the lead-lag output is still settling by a few lsb when the checks run
  task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
    logic [15:0] d;
    d = got - exp;
    compares++;
    if ((^got === 1'bx) || (d > 16'h0040 && d < 16'hFFC0)) begin
      n_fail++;
      $display("unexpected at %0t: angle %h near %h", $time, got, exp);
    end
  endtask : chk_near
  task automatic rd(input logic m3, input logic [4:0] ad, input logic [7:0] v);
    ctl_u.xfer(m3, {`ASPI_CMD_READ, ad, 8'h00}, 16, rx);
    ctl_u.xfer(m3, 16'h0000, 16, rx);
    chk(rx, {v, 8'h00});
  endtask : rd
  task automatic wr(input logic m3, input logic [4:0] ad, input logic [7:0] v);
    ctl_u.xfer(m3, {`ASPI_CMD_WRITE, ad, v}, 16, rx);
    // memory update wait before the readout
    repeat (NVM + 20) @(posedge clk);
    ctl_u.xfer(m3, 16'h0000, 16, rx);
    chk(rx, {v, 8'h00});
  endtask : wr
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // pin pairs checked every cycle, away from the launching edge
  always @(negedge clk) begin
    if (rst_n) begin
      chk({13'h0000, a_n, b_n, z_n}, {13'h0000, ~a, ~b, ~z});
      chk({14'h0000, oe, pd_en}, {14'h0000, ~cs_n, cs_n});
    end
  end
  initial begin
    #700_000;
    n_fail++;
    $display("unexpected at %0t: run hung", $time);
    give_verdict();
  end
  initial begin
    logic [4:0] ads [5];
    logic [7:0] vals [5];
    ads = '{`ASPI_REG_ZERO_LO, `ASPI_REG_ZERO_HI, `ASPI_REG_PPT_LO, `ASPI_REG_PPT_HI,
            `ASPI_REG_THRESH};
    vals = '{8'h00, 8'h00, `ASPI_RST_PPT_LO, `ASPI_RST_PPT_HI, `ASPI_RST_THRESH};
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    raw = 16'h0000;
    fld = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({ang[15:3], a, b, z} | {13'h0000, flo, fhi, 1'b0}, 16'h0001);
    // defaults read back in both modes
    for (int i = 0; i < 5; i++) begin
      rd(i[0], ads[i], vals[i]);
    end
    // a partial frame must not shift the next one
    ctl_u.xfer(1'b0, {`ASPI_CMD_READ, `ASPI_REG_PPT_LO, 8'h00}, 8, rx);
    rd(1'b1, `ASPI_REG_PPT_HI, `ASPI_RST_PPT_HI);
    // early acknowledge still shows the old threshold byte
    ctl_u.xfer(1'b0, {`ASPI_CMD_WRITE, `ASPI_REG_THRESH, 8'h94}, 16, rx);
    ctl_u.xfer(1'b0, 16'h0000, 16, rx);
    chk(rx, {`ASPI_RST_THRESH, 8'h00});
    repeat (NVM + 20) @(posedge clk);
    rd(1'b0, `ASPI_REG_THRESH, 8'h94);
    // low threshold 4, high threshold 5; levels straddle both
    for (int k = 3; k < 7; k++) begin
      @(posedge clk);
      fld <= {k[2:0], 5'h00};
      repeat (20) @(posedge clk);
      chk({14'h0000, flo, fhi}, {14'h0000, k < 4, k > 5});
      rd(k[0], `ASPI_REG_FLAGS, {k > 5, k < 4, 6'h00});
    end
    @(posedge clk);
    raw <= 16'h4A30;
    repeat (20000) @(posedge clk);
    chk_near(ang, 16'h4A30);
    ctl_u.xfer(1'b0, 16'h0000, 16, rx);
    ctl_u.xfer(1'b1, 16'h0000, 16, rx);
    chk_near(rx, 16'h4A30);
    wr(1'b1, `ASPI_REG_DIR, 8'h80);
    repeat (20000) @(posedge clk);
    chk_near(ang, 16'hB5D0);
    give_verdict();
  end
endmodule : test_angle_sensor_spi_config_port
